// ==== hdl/compressor_remote.sv ====
/*
 * Compressor end of the remote link: power-up wait, one-time operating mode
 * selection, input qualification, pump and cryocooler run control, answer
 * and alarm contacts.
 * Assumes the link inputs are synchronous to clk_sys_i and that the fault
 * and panel reset inputs come from local, already synchronous logic.
 */
//
// Functional notes
// R1: first used compressor input fixes the mode
// R2: mode kept until power removed
// R3: equipment uses one mode, never both
// R4: equipment drives only its mode's lines
// R5: start pulse over 0.3 s latches pump on
// R6: stop hold low over 0.3 s stops all
// R7: equipment keeps stop hold high normally
// R8: alternate mode: pump follows run level
// R9: alternate cooler needs run level and request
// R10: pump start alone starts no cryocooler
// R11: six command inputs, five contact outputs
// R12: no cooler answer while pump stopped
// R13: answer follows command within 0.3 s
// R14: ignore inputs, drive nothing during init (fault_i is still latched during init)
// R15: alarm latched until reset after fault clears
// R16: sub-0.3 s pulses and dropouts are ignored
`include "crc_defs.svh"

module compressor_remote #(
  parameter int unsigned QUAL_CYCLES = `CRC_QUAL_CYCLES,
  parameter int unsigned INIT_CYCLES = `CRC_INIT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // remote link
  crc_link_if.device link,
  // local compressor side
  input wire logic fault_i,
  input wire logic manual_reset_i,
  output logic ready_o,
  output logic momentary_mode_o,
  output logic alternate_mode_o,
  output logic pump_run_o,
  output logic [2:0] cooler_run_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input qualification

  logic [`CRC_NUM_INPUTS-1:0] raw_in;
  logic [`CRC_NUM_INPUTS-1:0] qual_ff;

  assign raw_in = {link.cooler_request, link.run_level, link.stop_hold,
                   link.start_pulse}; // see R11

  // a level is taken only after it differs from the qualified value for
  // QUAL_CYCLES cycles in a row; any bounce restarts the count
  genvar gi;
  generate
    for (gi = 0; gi < `CRC_NUM_INPUTS; gi++) begin : g_qual
      logic [31:0] cnt_ff;

      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt_ff <= 32'h0000_0000;
          qual_ff[gi] <= 1'b0;
        end else if (raw_in[gi] == qual_ff[gi]) begin
          cnt_ff <= 32'h0000_0000; // see R16
        end else if (cnt_ff >= QUAL_CYCLES - 1) begin
          cnt_ff <= 32'h0000_0000;
          qual_ff[gi] <= raw_in[gi]; // see R16
        end else begin
          cnt_ff <= cnt_ff + 32'h0000_0001;
        end
      end
    end
  endgenerate

  logic start_q;
  logic stop_q;
  logic run_q;
  logic [2:0] req_q;

  assign start_q = qual_ff[`CRC_IN_START];
  assign stop_q = qual_ff[`CRC_IN_STOP];
  assign run_q = qual_ff[`CRC_IN_RUN];
  assign req_q = qual_ff[`CRC_IN_REQ0 +: `CRC_NUM_COOLERS];

  ////////////////////////////////////////////////////////////////////////////
  // power-up wait and mode selection

  crc_pkg::dev_state_t state_ff;
  crc_pkg::dev_state_t nxt_state;
  logic [31:0] init_cnt_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_cnt_ff <= 32'h0000_0000;
    end else if (state_ff == crc_pkg::dev_init) begin
      init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      crc_pkg::dev_init: begin
        if (init_cnt_ff >= INIT_CYCLES - 1) begin
          nxt_state = crc_pkg::dev_select; // see R14
        end
      end
      crc_pkg::dev_select: begin
        // start line wins a tie; a compliant controller never makes one
        if (start_q) begin
          nxt_state = crc_pkg::dev_momentary; // see R1
        end else if (run_q) begin
          nxt_state = crc_pkg::dev_alternate; // see R1
        end
      end
      // both modes are final: only a power cycle (reset) leaves them
      crc_pkg::dev_momentary: nxt_state = crc_pkg::dev_momentary; // see R2
      crc_pkg::dev_alternate: nxt_state = crc_pkg::dev_alternate; // see R2
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= crc_pkg::dev_init;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pump and cryocooler control

  logic pump_on_ff;
  logic nxt_pump_on;
  logic [2:0] nxt_cooler_on;

  always_comb begin
    nxt_pump_on = 1'b0;
    unique case (state_ff)
      crc_pkg::dev_init: nxt_pump_on = 1'b0; // see R14
      crc_pkg::dev_select: begin
        // the selecting start pulse also starts the pump
        nxt_pump_on = start_q && stop_q; // see R5
      end
      crc_pkg::dev_momentary: begin
        // stop wins over start: a dropped hold line always stops
        if (!stop_q) begin
          nxt_pump_on = 1'b0; // see R6
        end else if (start_q) begin
          nxt_pump_on = 1'b1; // see R5
        end else begin
          nxt_pump_on = pump_on_ff; // see R5
        end
      end
      crc_pkg::dev_alternate: nxt_pump_on = run_q; // see R8
    endcase
  end

  always_comb begin
    nxt_cooler_on = 3'h0;
    unique case (state_ff)
      crc_pkg::dev_momentary: begin
        // coolers need their own request; pump start alone runs none
        nxt_cooler_on = (nxt_pump_on ? 3'h7 : 3'h0) & req_q; // see R10 R12 R6
      end
      crc_pkg::dev_alternate: begin
        nxt_cooler_on = (run_q ? 3'h7 : 3'h0) & req_q; // see R9 R8
      end
      crc_pkg::dev_init, crc_pkg::dev_select: nxt_cooler_on = 3'h0; // see R14
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_on_ff <= 1'b0;
    end else begin
      pump_on_ff <= nxt_pump_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm latch

  logic alarm_ff;

  // fault sets even while the panel reset is pressed; clearing needs the
  // fault gone first
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_ff <= 1'b0;
    end else if (fault_i) begin
      alarm_ff <= 1'b1; // see R15
    end else if (manual_reset_i) begin
      alarm_ff <= 1'b0; // see R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // contact outputs

  logic pump_answer_ff;
  logic alarm_contact_ff;
  logic [2:0] cooler_answer_ff;
  logic active;

  assign active = (state_ff != crc_pkg::dev_init);

  // pump answer lags the qualified command by two cycles (three when run level selects alternate mode), cooler answers by one to three, far inside 0.3 s
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_answer_ff <= `CRC_CONTACT_RST;
      cooler_answer_ff <= {`CRC_NUM_COOLERS{`CRC_CONTACT_RST}};
    end else begin
      pump_answer_ff <= pump_on_ff; // see R13
      cooler_answer_ff <= nxt_cooler_on & (pump_on_ff ? 3'h7 : 3'h0); // see R12 R13
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_contact_ff <= `CRC_CONTACT_RST;
    end else begin
      alarm_contact_ff <= alarm_ff && active; // see R14 R15
    end
  end

  assign link.pump_answer = pump_answer_ff;
  assign link.alarm_contact = alarm_contact_ff;
  assign link.cooler_answer = cooler_answer_ff;

  ////////////////////////////////////////////////////////////////////////////
  // local status

  logic ready_ff;
  logic momentary_ff;
  logic alternate_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_ff <= 1'b0;
      momentary_ff <= 1'b0;
      alternate_ff <= 1'b0;
    end else begin
      ready_ff <= active;
      momentary_ff <= (state_ff == crc_pkg::dev_momentary);
      alternate_ff <= (state_ff == crc_pkg::dev_alternate);
    end
  end

  assign ready_o = ready_ff;
  assign momentary_mode_o = momentary_ff;
  assign alternate_mode_o = alternate_ff;
  assign pump_run_o = pump_answer_ff;
  assign cooler_run_o = cooler_answer_ff;

endmodule : compressor_remote

// ==== hdl/sequence_controller.sv ====
/*
 * Equipment end of the remote link: turns a local run request and cooler
 * requests into the command lines of one fixed operating mode.
 * Assumes the compressor contacts are synchronous to clk_sys_i.
 */
`include "crc_defs.svh"

module sequence_controller #(
  parameter bit ALTERNATE_MODE = 1'b0,
  parameter int unsigned PULSE_CYCLES = `CRC_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // remote link
  crc_link_if.equipment link,
  // local user side
  input wire logic run_cmd_i,
  input wire logic [2:0] cooler_cmd_i,
  output logic pump_running_o,
  output logic [2:0] cooler_running_o,
  output logic alarm_o
);

  ////////////////////////////////////////////////////////////////////////////
  // momentary pulse sequencer

  crc_pkg::eq_state_t state_ff;
  logic [31:0] pulse_cnt_ff;
  logic pulse_done;

  assign pulse_done = (pulse_cnt_ff >= PULSE_CYCLES - 1);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= crc_pkg::eq_idle;
    end else if (!ALTERNATE_MODE) begin
      unique case (state_ff)
        crc_pkg::eq_idle: if (run_cmd_i) state_ff <= crc_pkg::eq_start_pulse;
        crc_pkg::eq_start_pulse: if (pulse_done) state_ff <= crc_pkg::eq_running;
        crc_pkg::eq_running: if (!run_cmd_i) state_ff <= crc_pkg::eq_stop_pulse;
        crc_pkg::eq_stop_pulse: if (pulse_done) state_ff <= crc_pkg::eq_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_cnt_ff <= 32'h0000_0000;
    end else if ((state_ff == crc_pkg::eq_start_pulse || state_ff == crc_pkg::eq_stop_pulse)
                 && !pulse_done) begin
      pulse_cnt_ff <= pulse_cnt_ff + 32'h0000_0001;
    end else begin
      pulse_cnt_ff <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command lines

  logic start_ff;
  logic stop_ff;
  logic run_ff;
  logic [2:0] req_ff;

  // the unused mode's lines stay low, as if unwired
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      run_ff <= 1'b0;
      req_ff <= 3'h0;
    end else if (ALTERNATE_MODE) begin
      start_ff <= 1'b0; // see R3 R4
      stop_ff <= 1'b0; // see R4
      run_ff <= run_cmd_i; // see R8
      req_ff <= cooler_cmd_i & (run_cmd_i ? 3'h7 : 3'h0); // see R9
    end else begin
      run_ff <= 1'b0; // see R3 R4
      start_ff <= (state_ff == crc_pkg::eq_start_pulse); // see R5
      stop_ff <= (state_ff != crc_pkg::eq_stop_pulse); // see R7 R6
      // cooler requests only once the pump answers
      req_ff <= cooler_cmd_i & ((state_ff == crc_pkg::eq_running && link.pump_answer)
                                ? 3'h7 : 3'h0); // see R10
    end
  end

  assign link.start_pulse = start_ff;
  assign link.stop_hold = stop_ff;
  assign link.run_level = run_ff;
  assign link.cooler_request = req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // status back to the user

  logic pump_ff;
  logic [2:0] cooler_ff;
  logic alarm_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_ff <= 1'b0;
      cooler_ff <= 3'h0;
      alarm_ff <= 1'b0;
    end else begin
      pump_ff <= link.pump_answer;
      cooler_ff <= link.cooler_answer;
      alarm_ff <= link.alarm_contact;
    end
  end

  assign pump_running_o = pump_ff;
  assign cooler_running_o = cooler_ff;
  assign alarm_o = alarm_ff;

endmodule : sequence_controller

// ==== shared/crc_defs.svh ====
/*
 * Timing counts, line positions and reset values shared by both ends of the
 * compressor remote-control link.
 * Assumes a 50 MHz system clock on both ends.
 */
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// clock rate in kHz, so a time in ms times this gives cycles
`define CRC_CLK_KHZ 50000

// times as printed, in milliseconds
`define CRC_QUAL_TIME_MS 300
`define CRC_INIT_TIME_MS 5000
// equipment pulse: comfortably longer than the qualification time
`define CRC_PULSE_TIME_MS 400

// derived cycle counts (whole ms, so no rounding is needed)
`define CRC_QUAL_CYCLES (`CRC_QUAL_TIME_MS * `CRC_CLK_KHZ)
`define CRC_INIT_CYCLES (`CRC_INIT_TIME_MS * `CRC_CLK_KHZ)
`define CRC_PULSE_CYCLES (`CRC_PULSE_TIME_MS * `CRC_CLK_KHZ)

// number of cryocooler channels
`define CRC_NUM_COOLERS 3

// positions of the six command lines in the device's qualifier vector
`define CRC_IN_START 0
`define CRC_IN_STOP 1
`define CRC_IN_RUN 2
`define CRC_IN_REQ0 3
`define CRC_NUM_INPUTS 6

// reset value of every contact output: open
`define CRC_CONTACT_RST 1'b0

`endif

// ==== shared/crc_link_if.sv ====
/*
 * Remote link between the equipment-side sequence controller and the
 * compressor: six command lines in, five contact outputs back.
 * Assumes both ends run on the same system clock; a contact reads 1 closed.
 */
interface crc_link_if;
  // commands, equipment to compressor
  logic start_pulse;
  logic stop_hold;
  logic run_level;
  logic [2:0] cooler_request;
  // contacts, compressor to equipment
  logic pump_answer;
  logic alarm_contact;
  logic [2:0] cooler_answer;

  modport device (
    input start_pulse,
    input stop_hold,
    input run_level,
    input cooler_request,
    output pump_answer,
    output alarm_contact,
    output cooler_answer
  );

  modport equipment (
    output start_pulse,
    output stop_hold,
    output run_level,
    output cooler_request,
    input pump_answer,
    input alarm_contact,
    input cooler_answer
  );
endinterface : crc_link_if

// ==== shared/crc_pkg.sv ====
/*
 * Types shared by the compressor remote-control ends.
 * Assumes nothing of its surroundings.
 */
package crc_pkg;

  // device: power-up wait, mode selection, then one mode until power-off
  typedef enum logic [1:0] {
    dev_init = 2'b00,
    dev_select = 2'b01,
    dev_momentary = 2'b11,
    dev_alternate = 2'b10
  } dev_state_t;

  // equipment end, momentary mode pulse sequencer
  typedef enum logic [1:0] {
    eq_idle = 2'b00,
    eq_start_pulse = 2'b01,
    eq_running = 2'b11,
    eq_stop_pulse = 2'b10
  } eq_state_t;

endpackage : crc_pkg

// ==== verif/crc_link_asserts.sv ====
/* assertions on the link between the equipment end and the device end
   assumes the counts match the device instance and a momentary-mode equipment end */
module crc_link_asserts #(
  parameter int unsigned QUAL_CYCLES = 8,
  parameter int unsigned INIT_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // link lines
  input wire logic start_pulse,
  input wire logic stop_hold,
  input wire logic run_level,
  input wire logic [2:0] cooler_request,
  input wire logic pump_answer,
  input wire logic alarm_contact,
  input wire logic [2:0] cooler_answer
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned hi_cnt_ff;
  int unsigned low_cnt_ff;
  int unsigned init_cnt_ff;
  logic long_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt_ff <= 0;
    else hi_cnt_ff <= start_pulse ? hi_cnt_ff + 1 : 0;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) low_cnt_ff <= 0;
    else low_cnt_ff <= stop_hold ? 0 : low_cnt_ff + 1;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) init_cnt_ff <= 0;
    else if (init_cnt_ff < INIT_CYCLES) init_cnt_ff <= init_cnt_ff + 1;
  end
  // cleared once the pump answers, so each start needs its own long pulse
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) long_ff <= 1'b0;
    else if (hi_cnt_ff >= QUAL_CYCLES) long_ff <= 1'b1;
    else if (pump_answer) long_ff <= 1'b0;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_init_quiet;
    init_cnt_ff < INIT_CYCLES |-> !pump_answer && !alarm_contact && cooler_answer == 3'h0;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("contact closed during init");
  property p_cooler_needs_pump;
    cooler_answer != 3'h0 |-> pump_answer;
  endproperty
  a_cooler_needs_pump: assert property (p_cooler_needs_pump)
    else $error("cooler answer without pump");
  property p_start_long;
    $rose(pump_answer) |-> long_ff;
  endproperty
  a_start_long: assert property (p_start_long)
    else $error("pump started without long start pulse");
  property p_start_hold;
    $rose(pump_answer) |-> stop_hold;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("pump started while stop line low");
  property p_start_answer;
    hi_cnt_ff == QUAL_CYCLES && stop_hold |-> ##[1:3] pump_answer;
  endproperty
  a_start_answer: assert property (p_start_answer)
    else $error("pump answer late after start");
  property p_stop_long;
    $fell(pump_answer) |-> low_cnt_ff >= QUAL_CYCLES;
  endproperty
  a_stop_long: assert property (p_stop_long)
    else $error("pump stopped without long stop dropout");
  property p_stop_answer;
    low_cnt_ff == QUAL_CYCLES |-> ##[1:3] (!pump_answer && cooler_answer == 3'h0);
  endproperty
  a_stop_answer: assert property (p_stop_answer)
    else $error("pump or cooler still on after stop");
  property p_cooler_req;
    $changed(cooler_answer) |-> (cooler_answer & ~$past(cooler_answer) & ~cooler_request) == 3'h0;
  endproperty
  a_cooler_req: assert property (p_cooler_req)
    else $error("cooler started without its request");
  // a momentary end must leave the alternate line as if unwired
  property p_mode_lines;
    !run_level;
  endproperty
  a_mode_lines: assert property (p_mode_lines)
    else $error("alternate line driven by momentary end");
endmodule : crc_link_asserts

// ==== verif/tb_top.sv ====
/* top bench: equipment end drives device end (momentary); a second device is
   driven by hand in alternate mode, with short pulses and other-mode lines.
   assumes qualification 8, init 20 and pulse 12 cycles */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned QUAL = 8;
  localparam int unsigned INIT = 20;
  // whole run is a few hundred cycles
  localparam int unsigned LIMIT = 2000;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic fault_i = 1'b0;
  logic manual_reset_i = 1'b0;
  logic run_cmd_i = 1'b0;
  logic [2:0] cooler_cmd_i = 3'h0;
  logic ready_o, momentary_mode_o, alternate_mode_o, pump_run_o, pump_running_o, alarm_o;
  logic [2:0] cooler_run_o, cooler_running_o, cool_b;
  logic ready_b, mom_b, alt_b, pump_b;
  int fails = 0;
  int checks_done = 0;
  crc_link_if link ();
  crc_link_if link_b ();

  always #10 clk_sys_i = ~clk_sys_i;

  compressor_remote #(.QUAL_CYCLES(QUAL), .INIT_CYCLES(INIT)) i_compressor_remote (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link), .fault_i(fault_i),
    .manual_reset_i(manual_reset_i), .ready_o(ready_o), .momentary_mode_o(momentary_mode_o),
    .alternate_mode_o(alternate_mode_o), .pump_run_o(pump_run_o), .cooler_run_o(cooler_run_o));
  sequence_controller #(.ALTERNATE_MODE(1'b0), .PULSE_CYCLES(12)) i_sequence_controller (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link), .run_cmd_i(run_cmd_i),
    .cooler_cmd_i(cooler_cmd_i), .pump_running_o(pump_running_o),
    .cooler_running_o(cooler_running_o), .alarm_o(alarm_o));
  compressor_remote #(.QUAL_CYCLES(QUAL), .INIT_CYCLES(INIT)) i_compressor_remote_b (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link_b), .fault_i(1'b0),
    .manual_reset_i(1'b0), .ready_o(ready_b), .momentary_mode_o(mom_b),
    .alternate_mode_o(alt_b), .pump_run_o(pump_b), .cooler_run_o(cool_b));
  crc_link_asserts #(.QUAL_CYCLES(QUAL), .INIT_CYCLES(INIT)) i_crc_link_asserts (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_pulse(link.start_pulse),
    .stop_hold(link.stop_hold), .run_level(link.run_level),
    .cooler_request(link.cooler_request),
    .pump_answer(link.pump_answer), .alarm_contact(link.alarm_contact),
    .cooler_answer(link.cooler_answer));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: seen %b expected %b", $time, what, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cycles

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // fault while still initialising: latched but contact held open
  task automatic t_init_alarm;
    fault_i = 1'b1;
    cycles(3);
    fault_i = 1'b0;
    cycles(5);
    check(3'(ready_o), 3'h0, "ready in init");
    check(3'(link.alarm_contact), 3'h0, "alarm in init");
    check(3'(link.pump_answer), 3'h0, "pump in init");
    cycles(INIT);
    check(3'(ready_o), 3'h1, "ready after init");
    check(3'(alarm_o), 3'h1, "alarm latched");
    fault_i = 1'b1;
    manual_reset_i = 1'b1;
    cycles(4);
    check(3'(link.alarm_contact), 3'h1, "reset during fault");
    fault_i = 1'b0;
    manual_reset_i = 1'b0;
    cycles(4);
    check(3'(link.alarm_contact), 3'h1, "fault gone, no reset");
    manual_reset_i = 1'b1;
    cycles(4);
    check(3'(link.alarm_contact), 3'h0, "alarm cleared");
    manual_reset_i = 1'b0;
  endtask : t_init_alarm

  task automatic t_momentary;
    run_cmd_i = 1'b1;
    cycles(QUAL + 8);
    check(3'({alternate_mode_o, momentary_mode_o}), 3'h1, "momentary mode");
    check(3'(link.pump_answer), 3'h1, "pump latched");
    check(3'(pump_run_o), 3'h1, "local pump status");
    check(3'(pump_running_o), 3'h1, "pump seen by equipment");
    check(link.cooler_answer, 3'h0, "no cooler with pump");
    cooler_cmd_i = 3'h5;
    cycles(QUAL + 6);
    check(link.cooler_answer, 3'h5, "coolers on request");
    check(cooler_run_o, 3'h5, "local cooler status");
    check(cooler_running_o, 3'h5, "coolers seen by equipment");
    run_cmd_i = 1'b0;
    cycles(QUAL + 8);
    check(3'(link.pump_answer), 3'h0, "pump stopped");
    check(link.cooler_answer, 3'h0, "coolers stopped");
    check(cooler_run_o, 3'h0, "local coolers stopped");
    cycles(20);
    check(3'(link.pump_answer), 3'h0, "pump stays stopped");
    cooler_cmd_i = 3'h0;
    run_cmd_i = 1'b1;
    cycles(QUAL + 8);
    check(3'({alternate_mode_o, link.pump_answer}), 3'h1, "restart same mode");
  endtask : t_momentary

  // second device: the bench breaks the one-mode wiring on purpose
  task automatic t_alternate;
    check(3'(ready_b), 3'h1, "second device ready");
    link_b.run_level = 1'b1;
    cycles(QUAL / 2);
    link_b.run_level = 1'b0;
    cycles(QUAL + 6);
    check(3'({alt_b, pump_b}), 3'h0, "short run level ignored");
    link_b.cooler_request = 3'h3;
    link_b.run_level = 1'b1;
    cycles(QUAL + 6);
    check(3'({alt_b, mom_b}), 3'h2, "alternate mode");
    check(3'(pump_b), 3'h1, "pump follows level");
    check(3'(link_b.pump_answer), 3'h1, "pump contact with level");
    check(cool_b, 3'h3, "coolers with level");
    check(3'(link_b.alarm_contact), 3'h0, "no alarm without fault");
    link_b.run_level = 1'b0;
    cycles(QUAL / 2);
    link_b.run_level = 1'b1;
    link_b.start_pulse = 1'b1;
    link_b.stop_hold = 1'b1;
    cycles(QUAL + 6);
    check(3'(pump_b), 3'h1, "dropout ignored");
    link_b.start_pulse = 1'b0;
    link_b.stop_hold = 1'b0;
    cycles(QUAL + 6);
    check(3'({mom_b, pump_b}), 3'h1, "other mode lines ignored");
    link_b.run_level = 1'b0;
    cycles(QUAL + 6);
    check(3'(pump_b), 3'h0, "pump off with level");
    check(cool_b, 3'h0, "request alone runs no cooler");
  endtask : t_alternate

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    link_b.start_pulse = 1'b0;
    link_b.stop_hold = 1'b0;
    link_b.run_level = 1'b0;
    link_b.cooler_request = 3'h0;
    cycles(4);
    nrst_i = 1'b1;
    t_init_alarm();
    t_momentary();
    t_alternate();
    wrap_up();
  end

  initial begin
    repeat (LIMIT) @(posedge clk_sys_i);
    fails++;
    wrap_up();
  end
endmodule : tb_top
